// ===== common/usbg_pkg.sv
package usbg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCV_CTRL_OFS  = 8'h18;
  localparam logic [7:0] XMT_CTRL_OFS  = 8'h98;
  localparam logic [7:0] BAUD_DIV_OFS  = 8'h99;
  localparam logic [7:0] RCV_DATA_OFS  = 8'h1A;
  localparam logic [7:0] XMT_DATA_OFS  = 8'h19;

  // ----------------------------------------------------------------------
  // Transmit control field positions
  // ----------------------------------------------------------------------
  localparam int XC_CLK_SRC  = 7;
  localparam int XC_NINE     = 6;
  localparam int XC_TX_EN    = 5;
  localparam int XC_SYNC     = 4;
  localparam int XC_HIGH_BD  = 2;
  localparam int XC_SR_EMPTY = 1;
  localparam int XC_NINTH    = 0;

  // ----------------------------------------------------------------------
  // Receive control field positions
  // ----------------------------------------------------------------------
  localparam int RC_SP_EN    = 7;
  localparam int RC_NINE     = 6;
  localparam int RC_SINGLE   = 5;
  localparam int RC_CONT     = 4;
  localparam int RC_FRAMING_ERROR_FLAG     = 2;
  localparam int RC_OVERRUN_ERROR_FLAG     = 1;
  localparam int RC_NINTH    = 0;

  // ----------------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] XMT_CTRL_RST = 8'h02;
  localparam logic [7:0] RCV_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [7:0] XMT_WR_MASK  = 8'hF5;
  localparam logic [7:0] RCV_WR_MASK  = 8'hF0;

  // ----------------------------------------------------------------------
  // Prescale: clock ticks per baud tick, and ticks per bit
  // ----------------------------------------------------------------------
  localparam logic [5:0] PRE_SYNC     = 6'd1;
  localparam logic [5:0] PRE_ASYNC_LO = 6'd3;
  localparam logic [5:0] PRE_ASYNC_HI = 6'd0;
  localparam logic [4:0] TICKS_LO     = 5'd15;
  localparam logic [4:0] TICKS_HI     = 5'd15;
  localparam logic [4:0] SAMPLE_A     = 5'd6;
  localparam logic [4:0] SAMPLE_B     = 5'd7;
  localparam logic [4:0] SAMPLE_C     = 5'd8;

  typedef enum logic [1:0] {USBG_IDLE, USBG_START, USBG_DATA, USBG_STOP} usbg_rx_state_t;

endpackage

// ===== core/usbg_baud_gen.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------------
// Free-running divider: tick every (prescale+1)*(divisor+1) clocks.
// ------------------------------------------------------------------------
module usbg_baud_gen
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Control
  input  wire logic       i_restart,
  input  wire logic [7:0] i_divisor,
  input  wire logic [5:0] i_prescale,
  // Tick out
  output logic            o_tick
);

  logic [5:0] pre_q;
  logic [7:0] cnt_q;
  wire        pre_wrap = (pre_q >= i_prescale);
  wire        cnt_wrap = (cnt_q >= i_divisor);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || i_restart)
    begin
      pre_q  <= 6'h0;
      cnt_q  <= 8'h00;
      o_tick <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_wrap ? 6'h0 : pre_q + 6'd1;
      if (pre_wrap)
        cnt_q <= cnt_wrap ? 8'h00 : cnt_q + 8'd1;
      o_tick <= pre_wrap && cnt_wrap;
    end
  end

  default clocking cb_baud @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_wrap; pre_wrap && cnt_wrap && !i_restart; endsequence
  property p_tick_on_wrap; s_wrap |=> o_tick; endproperty
  a_tick_on_wrap: assert property (p_tick_on_wrap) else $error("baud tick missing");
  property p_no_stray; !(pre_wrap && cnt_wrap) |=> !o_tick; endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray baud tick");
  property p_cnt_bound; cnt_q <= i_divisor; endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("baud count past divisor");
  property p_restart; i_restart |=> (pre_q == 6'h0) && (cnt_q == 8'h00) && !o_tick; endproperty
  a_restart: assert property (p_restart) else $error("baud timer not restarted");

endmodule

`default_nettype wire

// ===== core/usbg_core.sv
`timescale 1ns/100ps
`default_nettype none

//
// Contract
// - Three modes: asynchronous full duplex, synchronous master, synchronous slave.
// - Receive control bit 7 enables the serial port pins.
// - Transmit control bit 7 picks master or slave clock in synchronous mode.
// - Transmit control bit 6 selects nine-bit transmit frames.
// - Transmit control bit 5 enables transmit; receive enables override it synchronously.
// - Transmit control bit 4 selects synchronous mode.
// - Transmit control bit 2 selects high baud speed, asynchronous only.
// - Transmit control bit 1 shows shift register empty, resets to one.
// - Transmit control bit 0 holds ninth transmit bit.
// - Receive control bit 6 selects nine-bit reception.
// - Bit 5 single receive, master only, cleared by hardware when done.
// - Bit 4 continuous receive, overrides single receive.
// - Bit 2 framing error, refreshed with each byte loaded into the receive buffer.
// - Bit 1 overrun error, cleared only by clearing continuous receive.
// - Bit 0 ninth received bit, read only.
// - Baud generator is a free-running 8-bit timer set by divisor.
// - Asynchronous baud is clock/(64(X+1)) low or clock/(16(X+1)) high.
// - Synchronous master baud is clock/(4(X+1)).
// - Writing the divisor restarts the baud timer at once.
// - Asynchronous receive pin sampled three times per bit, majority decides; synchronous takes the pin directly.
// - Asynchronous frames: start, eight or nine data LSB first, stop.
module usbg_core
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_sys_rst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Transmit/clock pin
  input  wire logic       i_txck,
  output logic            o_txck,
  output logic            o_txck_oe,
  // Receive/data pin
  input  wire logic       i_rxdt,
  output logic            o_rxdt,
  output logic            o_rxdt_oe
);
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] xctl_q;
  logic [7:0] rctl_q;
  logic [7:0] div_q;
  logic [7:0] txbuf_q;
  logic       txbuf_full_q;
  logic [7:0] rxbuf_q;
  logic       rxbuf_full_q;
  logic       framing_error_flag_q;
  logic       overrun_error_flag_q;
  logic       rx9_q;

  wire wr_x   = i_wr && (i_addr == usbg_pkg::XMT_CTRL_OFS);
  wire wr_r   = i_wr && (i_addr == usbg_pkg::RCV_CTRL_OFS);
  wire wr_d   = i_wr && (i_addr == usbg_pkg::BAUD_DIV_OFS);
  wire wr_t   = i_wr && (i_addr == usbg_pkg::XMT_DATA_OFS);
  wire rd_buf = i_rd && (i_addr == usbg_pkg::RCV_DATA_OFS);

  wire sp_en    = rctl_q[usbg_pkg::RC_SP_EN];
  wire sync_md  = xctl_q[usbg_pkg::XC_SYNC];
  wire master   = xctl_q[usbg_pkg::XC_CLK_SRC];
  wire high_bd  = xctl_q[usbg_pkg::XC_HIGH_BD];
  wire continuous_receive_enable     = rctl_q[usbg_pkg::RC_CONT];
  wire single_receive_enable_act = sync_md && master && rctl_q[usbg_pkg::RC_SINGLE];
  wire rx_en    = sp_en && (continuous_receive_enable || single_receive_enable_act);
  wire tx_en    = sp_en && xctl_q[usbg_pkg::XC_TX_EN] && !(sync_md && (continuous_receive_enable || single_receive_enable_act));

  // ----------------------------------------------------------------------
  // Baud generator
  // ----------------------------------------------------------------------
  logic       tick;
  wire  [5:0] prescale = sync_md ? usbg_pkg::PRE_SYNC :
                         (high_bd ? usbg_pkg::PRE_ASYNC_HI : usbg_pkg::PRE_ASYNC_LO);

  usbg_baud_gen u_baud
  (
    .i_sys_clk  (i_sys_clk),
    .i_sys_rst  (i_sys_rst),
    .i_restart  (wr_d),
    .i_divisor  (div_q),
    .i_prescale (prescale),
    .o_tick     (tick)
  );

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] rx_s_q;
  logic [1:0] ck_s_q;
  logic       ck_d_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      rx_s_q <= 2'b11;
      ck_s_q <= 2'b00;
      ck_d_q <= 1'b0;
    end
    else
    begin
      rx_s_q <= {rx_s_q[0], i_rxdt};
      ck_s_q <= {ck_s_q[0], i_txck};
      ck_d_q <= ck_s_q[1];
    end
  end
  wire rx_in   = rx_s_q[1];
  wire ck_rise = ck_s_q[1] && !ck_d_q;
  wire ck_fall = !ck_s_q[1] && ck_d_q;

  // Sixteen ticks per async bit; in synchronous master mode a tick is half a clock.
  logic [4:0] sub_q, tsub_q;
  logic [2:0] smp_q;
  logic       sck_q;
  wire  [4:0] tpb = high_bd ? usbg_pkg::TICKS_HI : usbg_pkg::TICKS_LO;
  wire        async_bit_end = tick && (sub_q == tpb);
  wire        t_bit_end     = tick && (tsub_q == tpb);
  wire        maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  wire        shift_in_edge  = sync_md ? (master ? (tick && sck_q) : ck_rise) : async_bit_end;
  wire        shift_out_edge = sync_md ? (master ? (tick && !sck_q) : ck_fall) : t_bit_end;

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  logic [9:0] tsr_q;
  logic [3:0] tcnt_q;
  logic       tbusy_q;
  wire        t_nine  = xctl_q[usbg_pkg::XC_NINE];
  wire [3:0]  t_bits  = sync_md ? (t_nine ? 4'd9 : 4'd8) : (t_nine ? 4'd11 : 4'd10);
  wire        t_load  = tx_en && txbuf_full_q && !tbusy_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || !tx_en)
    begin
      tsr_q   <= 10'h3FF;
      tcnt_q  <= 4'd0;
      tsub_q  <= 5'd0;
      tbusy_q <= 1'b0;
    end
    else if (t_load)
    begin
      // (async: start bit first, LSB first); ninth bit.
      tsr_q   <= sync_md ? {1'b1, xctl_q[usbg_pkg::XC_NINTH], txbuf_q}
                         : {xctl_q[usbg_pkg::XC_NINTH], txbuf_q, 1'b0};
      tcnt_q  <= 4'd0;
      tsub_q  <= 5'd0;
      tbusy_q <= 1'b1;
    end
    else if (tbusy_q && shift_out_edge)
    begin
      tsr_q  <= {1'b1, tsr_q[9:1]};
      tcnt_q <= tcnt_q + 4'd1;
      tsub_q <= 5'd0;
      if (tcnt_q + 4'd1 == t_bits)
        tbusy_q <= 1'b0;
    end
    else if (tick)
      tsub_q <= tsub_q + 5'd1;
  end

  // Async: stop bit is the idle high after a shifted-out nine/ten bit frame.
  wire t_line = (!t_nine && !sync_md && tcnt_q == 4'd9) ? 1'b1 : tsr_q[0];

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  usbg_pkg::usbg_rx_state_t rst_q;
  logic [8:0] rsr_q;
  logic [3:0] rcnt_q;
  wire        r_nine = rctl_q[usbg_pkg::RC_NINE];
  wire [3:0]  r_bits = r_nine ? 4'd9 : 4'd8;
  logic       r_done;
  logic       r_framing_error_flag;
  wire        r_bit  = sync_md ? rx_in : maj;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || !rx_en)
    begin
      rst_q  <= usbg_pkg::USBG_IDLE;
      rsr_q  <= 9'h000;
      rcnt_q <= 4'd0;
      sub_q  <= 5'd0;
      smp_q  <= 3'b111;
      r_done <= 1'b0;
      r_framing_error_flag <= 1'b0;
    end
    else
    begin
      r_done <= 1'b0;
      if (tick)
      begin
        sub_q <= (sub_q == tpb) ? 5'd0 : sub_q + 5'd1;
        if (sub_q == usbg_pkg::SAMPLE_A) smp_q[0] <= rx_in;
        if (sub_q == usbg_pkg::SAMPLE_B) smp_q[1] <= rx_in;
        if (sub_q == usbg_pkg::SAMPLE_C) smp_q[2] <= rx_in;
      end
      case (rst_q)
        usbg_pkg::USBG_IDLE:
        begin
          rcnt_q <= 4'd0;
          if (sync_md)
            rst_q <= usbg_pkg::USBG_DATA;
          else if (!rx_in)
          begin
            sub_q <= 5'd0;
            rst_q <= usbg_pkg::USBG_START;
          end
        end
        usbg_pkg::USBG_START:
          if (async_bit_end)
            rst_q <= maj ? usbg_pkg::USBG_IDLE : usbg_pkg::USBG_DATA;
        usbg_pkg::USBG_DATA:
          if (shift_in_edge)
          begin
            rsr_q  <= r_nine ? {r_bit, rsr_q[8:1]} : {1'b0, r_bit, rsr_q[7:1]};
            rcnt_q <= rcnt_q + 4'd1;
            if (rcnt_q + 4'd1 == r_bits)
            begin
              if (sync_md)
              begin
                r_done <= 1'b1;
                r_framing_error_flag <= 1'b0;
                rst_q  <= usbg_pkg::USBG_IDLE;
              end
              else
                rst_q <= usbg_pkg::USBG_STOP;
            end
          end
        usbg_pkg::USBG_STOP:
          if (async_bit_end)
          begin
            r_done <= 1'b1;
            r_framing_error_flag <= !maj;
            rst_q  <= usbg_pkg::USBG_IDLE;
          end
        default:
          rst_q <= usbg_pkg::USBG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and status
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      xctl_q       <= usbg_pkg::XMT_CTRL_RST;
      rctl_q       <= usbg_pkg::RCV_CTRL_RST;
      div_q        <= usbg_pkg::BAUD_DIV_RST;
      txbuf_q      <= 8'h00;
      txbuf_full_q <= 1'b0;
      rxbuf_q      <= 8'h00;
      rxbuf_full_q <= 1'b0;
      framing_error_flag_q       <= 1'b0;
      overrun_error_flag_q       <= 1'b0;
      rx9_q        <= 1'b0;
      sck_q        <= 1'b1;
    end
    else
    begin
      if (wr_x)
        xctl_q <= (i_wdata & usbg_pkg::XMT_WR_MASK) | (xctl_q & ~usbg_pkg::XMT_WR_MASK);
      xctl_q[usbg_pkg::XC_SR_EMPTY] <= !(tbusy_q || t_load);
      if (wr_d)
        div_q <= i_wdata;
      if (wr_t)
        txbuf_q <= i_wdata;
      if (wr_t)
        txbuf_full_q <= 1'b1;
      else if (t_load)
        txbuf_full_q <= 1'b0;
      if (wr_r)
        rctl_q <= (i_wdata & usbg_pkg::RCV_WR_MASK) | (rctl_q & ~usbg_pkg::RCV_WR_MASK);
      if (r_done && single_receive_enable_act && !continuous_receive_enable)
        rctl_q[usbg_pkg::RC_SINGLE] <= 1'b0;
      if (!continuous_receive_enable)
        overrun_error_flag_q <= 1'b0;
      else if (r_done && rxbuf_full_q && !rd_buf)
        overrun_error_flag_q <= 1'b1;
      if (r_done && !(rxbuf_full_q && !rd_buf))
      begin
        rxbuf_q      <= rsr_q[7:0];
        rx9_q        <= rsr_q[8];
        framing_error_flag_q       <= r_framing_error_flag;
        rxbuf_full_q <= 1'b1;
      end
      else if (rd_buf)
        rxbuf_full_q <= 1'b0;
      if (tick && sync_md && master)
        sck_q <= !sck_q;
      else if (!(sync_md && master))
        sck_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and pins
  // ----------------------------------------------------------------------
  wire [7:0] rctl_rd = {rctl_q[7:4], 1'b0, framing_error_flag_q, overrun_error_flag_q, rx9_q};
  wire [7:0] rd_mux  = (i_addr == usbg_pkg::XMT_CTRL_OFS) ? {xctl_q[7:4], 1'b0, xctl_q[2:0]} :
                       (i_addr == usbg_pkg::RCV_CTRL_OFS) ? rctl_rd :
                       (i_addr == usbg_pkg::BAUD_DIV_OFS) ? div_q :
                       (i_addr == usbg_pkg::RCV_DATA_OFS) ? rxbuf_q : 8'h00;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      o_rdata   <= 8'h00;
      o_txck    <= 1'b1;
      o_txck_oe <= 1'b0;
      o_rxdt    <= 1'b1;
      o_rxdt_oe <= 1'b0;
    end
    else
    begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
      // pin roles follow port enable and mode.
      if (!sp_en)
      begin
        o_txck_oe <= 1'b0;
        o_rxdt_oe <= 1'b0;
        o_txck    <= 1'b1;
        o_rxdt    <= 1'b1;
      end
      else if (!sync_md)
      begin
        o_txck_oe <= tx_en;
        o_txck    <= tbusy_q ? t_line : 1'b1;
        o_rxdt_oe <= 1'b0;
        o_rxdt    <= 1'b1;
      end
      else
      begin
        o_txck_oe <= master;
        o_txck    <= sck_q;
        o_rxdt_oe <= tx_en && tbusy_q;
        o_rxdt    <= tsr_q[0];
      end
    end
  end
  property p_sr_empty; tbusy_q |=> !xctl_q[usbg_pkg::XC_SR_EMPTY]; endproperty
  a_sr_empty: assert property (p_sr_empty) else $error("empty flag set while busy");
  property p_overrun_error_flag_clear; !continuous_receive_enable |=> !overrun_error_flag_q; endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear) else $error("overrun flag held");
  property p_port_off; !sp_en |=> !o_txck_oe && !o_rxdt_oe; endproperty
  a_port_off: assert property (p_port_off) else $error("pin driven while port off");

endmodule

`default_nettype wire

// ===== verification/usbg_term_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------
// Serial terminal: decodes device frames, sends frames.
// ----------------------------------------------------
module usbg_term_model
(
  // Clock
  input  wire logic        i_sys_clk,
  // Frame settings
  input  wire logic [15:0] i_bit_clks,
  input  wire logic        i_nine,
  // Line from the device
  input  wire logic        i_line,
  output logic       [8:0] o_word,
  output logic       [7:0] o_cnt,
  // Line to the device
  input  wire logic        i_send,
  input  wire logic  [8:0] i_data,
  input  wire logic        i_bad_stop,
  output logic             o_line,
  output logic             o_busy
);
  int i;
  int k;
  initial
  begin
    o_word = 9'h000;
    o_cnt = 8'h00;
    o_line = 1'b1;
    o_busy = 1'b0;
  end
  always
  begin
    @(negedge i_line);
    if (i_line === 1'b0)
    begin
      o_word = 9'h000;
      repeat (i_bit_clks / 2) @(posedge i_sys_clk);
      for (i = 0; i < (i_nine ? 9 : 8); i++)
      begin
        repeat (i_bit_clks) @(posedge i_sys_clk);
        o_word[i] = i_line;
      end
      repeat (i_bit_clks) @(posedge i_sys_clk);
      o_cnt = o_cnt + 8'h01;
    end
  end
  always @(posedge i_sys_clk)
  begin
    if (i_send)
    begin
      o_busy = 1'b1;
      o_line <= 1'b0;
      for (k = 0; k < (i_nine ? 9 : 8); k++)
      begin
        repeat (i_bit_clks) @(posedge i_sys_clk);
        o_line <= i_data[k];
      end
      repeat (i_bit_clks) @(posedge i_sys_clk);
      o_line <= ~i_bad_stop;
      repeat (i_bit_clks) @(posedge i_sys_clk);
      o_line <= 1'b1;
      o_busy = 1'b0;
    end
  end
endmodule

`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_txck, o_txck_oe, o_rxdt, o_rxdt_oe;
  logic [15:0] bit_clks = 16'h0010;
  logic nine = 1'b0;
  logic send = 1'b0;
  logic bad = 1'b0;
  logic [8:0] sdata = 9'h000;
  logic [8:0] m_word;
  logic [7:0] m_cnt;
  logic m_line, m_busy;
  wire tx_line = o_txck_oe ? o_txck : 1'b1;
  wire rx_line = o_rxdt_oe ? o_rxdt : m_line;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;

  always #10 i_sys_clk = ~i_sys_clk;

  usbg_core u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_txck(tx_line),
    .o_txck(o_txck), .o_txck_oe(o_txck_oe), .i_rxdt(rx_line), .o_rxdt(o_rxdt),
    .o_rxdt_oe(o_rxdt_oe));
  usbg_term_model u_term (.i_sys_clk(i_sys_clk), .i_bit_clks(bit_clks), .i_nine(nine),
    .i_line(tx_line), .o_word(m_word), .o_cnt(m_cnt), .i_send(send), .i_data(sdata),
    .i_bad_stop(bad), .o_line(m_line), .o_busy(m_busy));

  // ------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 g = o_rdata;
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_word(input string what, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_cnt(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
    end
  endtask
  task automatic send_frame(input logic [8:0] w, input logic b);
    @(posedge i_sys_clk);
    sdata <= w;
    bad <= b;
    send <= 1'b1;
    @(posedge i_sys_clk);
    send <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    for (n = 0; n < 3000 && m_busy === 1'b1; n++) @(posedge i_sys_clk);
    repeat (40) @(posedge i_sys_clk);
  endtask
  task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] d, input logic [8:0] e);
    logic [7:0] c0;
    c0 = m_cnt;
    wr_reg(8'h19, d);
    chk_reg("shift busy", 8'h98, ctl);
    for (n = 0; n < 3000 && m_cnt == c0; n++) @(posedge i_sys_clk);
    chk_word("tx word", e, m_word);
    repeat (bit_clks * 2) @(posedge i_sys_clk);
    chk_reg("shift empty", 8'h98, ctl | 8'h02);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    chk_reg("xmt reset", 8'h98, 8'h02);
    chk_reg("rcv reset", 8'h18, 8'h00);
    chk_reg("div reset", 8'h99, 8'h00);
    chk_cnt("pin off", 0, o_txck_oe + o_rxdt_oe);
    wr_reg(8'h98, 8'hFF);
    chk_reg("xmt mask", 8'h98, 8'hF7);
    wr_reg(8'h98, 8'h00);
    wr_reg(8'h18, 8'hFF);
    chk_reg("rcv mask", 8'h18, 8'hF0);
    wr_reg(8'h18, 8'h00);
    wr_reg(8'h99, 8'hA5);
    chk_reg("div rw", 8'h99, 8'hA5);
    chk_reg("unmapped", 8'h55, 8'h00);
    $display("test registers done");
    wr_reg(8'h99, 8'h00);
    wr_reg(8'h18, 8'h80);
    wr_reg(8'h98, 8'h24);
    repeat (2) @(posedge i_sys_clk);
    chk_cnt("tx pin on", 1, o_txck_oe);
    bit_clks <= 16'd16;
    tx_frame(8'h24, 8'hA5, 9'h0A5);
    $display("test async high done");
    wr_reg(8'h99, 8'h01);
    wr_reg(8'h98, 8'h61);
    bit_clks <= 16'd128;
    nine <= 1'b1;
    tx_frame(8'h61, 8'h3C, 9'h13C);
    $display("test async nine done");
    wr_reg(8'h98, 8'h04);
    wr_reg(8'h99, 8'h00);
    wr_reg(8'h18, 8'hD0);
    bit_clks <= 16'd16;
    send_frame(9'h15A, 1'b0);
    chk_reg("rx ninth", 8'h18, 8'hD1);
    chk_reg("rx data", 8'h1A, 8'h5A);
    send_frame(9'h0F1, 1'b1);
    chk_reg("framing", 8'h18, 8'hD4);
    send_frame(9'h022, 1'b0);
    chk_reg("overrun", 8'h18, 8'hD6);
    wr_reg(8'h18, 8'hC0);
    chk_reg("overrun clear", 8'h18, 8'hC4);
    $display("test receive done");
    wr_reg(8'h99, 8'h01);
    wr_reg(8'h98, 8'hB0);
    wr_reg(8'h18, 8'h80);
    wr_reg(8'h19, 8'h33);
    for (n = 0; n < 200 && o_txck !== 1'b0; n++) @(posedge i_sys_clk);
    for (n = 0; n < 200 && o_txck !== 1'b1; n++) @(posedge i_sys_clk);
    for (n = 0; n < 200 && o_txck === 1'b1; n++) @(posedge i_sys_clk);
    chk_cnt("sync half period", 4, n);
    chk_cnt("clock pin on", 1, o_txck_oe);
    $display("test sync master done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
